// >>> hdl/cclc_pkg.sv
`default_nettype none
package cclc_pkg;
    // current setting code width, steps of the programmed fast-charge current
    localparam int CCLC_CUR_W = 5;
    localparam logic [4:0] CCLC_CUR_MIN = 5'h01;
    localparam logic [4:0] CCLC_CUR_RST = 5'h00;
    // cool-battery reduction select
    localparam logic [1:0] CCLC_COOL_HALF = 2'h0;
    localparam logic [1:0] CCLC_COOL_QUARTER = 2'h1;
    localparam logic [1:0] CCLC_COOL_THREEQ = 2'h2;
    // timing
    localparam int CCLC_CLK_HZ = 10_000_000;
    localparam int CCLC_RESAMPLE_MS = 16;
    localparam int CCLC_RESAMPLE_CYC = CCLC_CLK_HZ / 1000 * CCLC_RESAMPLE_MS;
    localparam int CCLC_SLOW_STEP_US = 100;
    localparam int CCLC_SLOW_STEP_CYC = CCLC_CLK_HZ / 1_000_000 * CCLC_SLOW_STEP_US;
    localparam int CCLC_DONE2FC_US = 100;
    localparam int CCLC_DONE2FC_CYC = CCLC_CLK_HZ / 1_000_000 * CCLC_DONE2FC_US;
    localparam int CCLC_CNT_W = 20;
    typedef enum logic [1:0] {CCLC_IDLE, CCLC_DROOP, CCLC_HOLD} cclc_lim_e;
endpackage : cclc_pkg
`default_nettype wire

// >>> hdl/cclc_core.sv
`default_nettype none
// Summary of operation
// RULE1 - an input voltage below the upper droop threshold raises the droop flag, which steps the current down.
// RULE2 - on the first droop trip the current is decremented slowly until the input recovers.
// RULE3 - the lower droop comparator throttles the current down but never below the minimum code.
// RULE4 - after recovery from droop the current level is re-evaluated every resample interval.
// RULE5 - while input overcurrent is flagged the current is decremented slowly.
// RULE6 - once overcurrent clears the current is held for the resample interval, then sampled again.
// RULE7 - in region one a cool battery scales the current to half, or a quarter or three quarters by select.
// RULE8 - in region one a warm battery lowers the termination voltage target.
// RULE9 - when the current is halved for temperature the safety timer duration is doubled.
// RULE10 - in region two a cool or warm battery lowers the termination voltage target.
// RULE11 - in region two the current is never changed for temperature.
// RULE12 - the host-written region select bit chooses the active safety region.
// RULE13 - the host test-mode bit enables pulsed high-current test mode once charging settles in constant voltage.
// RULE14 - the safe-output regulator is enabled only while the input exceeds its turn-on threshold.
// RULE15 - the done-to-fast-charge transition completes within the fixed transition time.
// RULE16 - comparator and temperature inputs are synchronised and current steps happen on clock edges.
module cclc_core #(
    parameter int RESAMPLE_CYC = cclc_pkg::CCLC_RESAMPLE_CYC,
    parameter int SLOW_STEP_CYC = cclc_pkg::CCLC_SLOW_STEP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // analog comparators
    input wire logic vin_below_upper,
    input wire logic vin_below_lower,
    input wire logic input_overcurrent_flag,
    input wire logic vin_above_sfo_on,
    input wire logic batt_cool,
    input wire logic batt_warm,
    input wire logic cv_settled,
    input wire logic done_restart,
    // host settings
    input wire logic [cclc_pkg::CCLC_CUR_W-1:0] fast_current_prog,
    input wire logic [1:0] cool_scale_sel,
    input wire logic safety_region_select,
    input wire logic test_mode_bit,
    // outputs
    output logic [cclc_pkg::CCLC_CUR_W-1:0] fast_current_out,
    output logic input_voltage_droop_flag,
    output logic vterm_reduced,
    output logic timer_double,
    output logic test_mode_en,
    output logic safe_output_regulator,
    output logic fast_charge_start
);
    import cclc_pkg::*;

    localparam logic [CCLC_CNT_W-1:0] RES_N = CCLC_CNT_W'(RESAMPLE_CYC - 1);
    localparam logic [CCLC_CNT_W-1:0] STEP_N = CCLC_CNT_W'(SLOW_STEP_CYC - 1);

    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [CCLC_CUR_W-1:0] lim_reg;
    logic [CCLC_CNT_W-1:0] cnt_reg;
    cclc_lim_e st_reg;

    // synchronisers [RULE16]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
        end else begin
            s1_reg <= {done_restart, cv_settled, batt_warm, batt_cool, vin_above_sfo_on,
                       input_overcurrent_flag, vin_below_lower, vin_below_upper};
            s2_reg <= s1_reg;
        end
    end

    wire droop_hi = s2_reg[0];
    wire droop_lo = s2_reg[1];
    wire ovc = s2_reg[2];
    wire sfo_ok = s2_reg[3];
    wire cool = s2_reg[4];
    wire warm = s2_reg[5];
    wire cv_ok = s2_reg[6];
    wire restart = s2_reg[7];

    wire pressure = droop_hi | ovc;
    wire cnt_done = (cnt_reg == '0);
    wire above_min = lim_reg > CCLC_CUR_MIN;
    // lower comparator steps every clock, upper and overcurrent at the slow rate
    wire step_down = above_min & (droop_lo | (pressure & cnt_done)); // [RULE2] [RULE3] [RULE5]
    wire step_up = (st_reg == CCLC_HOLD) & cnt_done & ~pressure & (lim_reg < fast_current_prog); // [RULE4]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= CCLC_IDLE;
            cnt_reg <= '0;
            lim_reg <= CCLC_CUR_RST;
        end else begin
            case (st_reg)
                CCLC_IDLE: begin
                    lim_reg <= fast_current_prog;
                    if (pressure | droop_lo) begin
                        st_reg <= CCLC_DROOP;
                        cnt_reg <= STEP_N;
                    end
                end
                CCLC_DROOP: begin
                    if (step_down) begin
                        lim_reg <= lim_reg - 1'b1; // [RULE1] [RULE16]
                    end
                    if (!pressure && !droop_lo) begin
                        st_reg <= CCLC_HOLD;
                        cnt_reg <= RES_N; // [RULE6]
                    end else if (cnt_done) begin
                        cnt_reg <= STEP_N;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                CCLC_HOLD: begin
                    if (pressure || droop_lo) begin
                        st_reg <= CCLC_DROOP;
                        cnt_reg <= STEP_N;
                    end else if (cnt_done) begin
                        cnt_reg <= RES_N; // [RULE4] [RULE6]
                        if (step_up) begin
                            lim_reg <= lim_reg + 1'b1;
                        end else if (lim_reg >= fast_current_prog) begin
                            st_reg <= CCLC_IDLE;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: begin
                    st_reg <= CCLC_IDLE;
                end
            endcase
        end
    end

    // temperature scaling, region one only [RULE7] [RULE11] [RULE12]
    wire region_one = ~safety_region_select;
    wire cool_cut = region_one & cool;
    wire [CCLC_CUR_W+1:0] lim_x = {2'b00, lim_reg};
    wire [CCLC_CUR_W+1:0] three_q = (lim_x + (lim_x << 1)) >> 2;
    wire [CCLC_CUR_W-1:0] scaled =
        (cool_scale_sel == CCLC_COOL_QUARTER) ? (lim_reg >> 2) :
        (cool_scale_sel == CCLC_COOL_THREEQ) ? three_q[CCLC_CUR_W-1:0] : (lim_reg >> 1);
    wire [CCLC_CUR_W-1:0] cur_final = cool_cut ? scaled : lim_reg;
    wire half_sel = (cool_scale_sel != CCLC_COOL_QUARTER) & (cool_scale_sel != CCLC_COOL_THREEQ);
    wire halved = cool_cut & half_sel; // [RULE9]
    wire vred = region_one ? warm : (warm | cool); // [RULE8] [RULE10]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fast_current_out <= CCLC_CUR_RST;
            input_voltage_droop_flag <= 1'b0;
            vterm_reduced <= 1'b0;
            timer_double <= 1'b0;
            test_mode_en <= 1'b0;
            safe_output_regulator <= 1'b0;
            fast_charge_start <= 1'b0;
        end else begin
            fast_current_out <= cur_final;
            input_voltage_droop_flag <= droop_hi; // [RULE1]
            vterm_reduced <= vred;
            timer_double <= halved;
            test_mode_en <= test_mode_bit & cv_ok; // [RULE13]
            safe_output_regulator <= sfo_ok; // [RULE14]
            fast_charge_start <= restart; // [RULE15]
        end
    end
endmodule : cclc_core
`default_nettype wire

// >>> sim/cclc_core_chk.sv
`default_nettype none
module cclc_core_chk (
    // clock, reset and pins
    input wire logic ref_clk, rst_n, vin_below_upper, vin_above_sfo_on, batt_cool, batt_warm, cv_settled, done_restart,
    // host settings and current output
    input wire logic safety_region_select, test_mode_bit,
    input wire logic [1:0] cool_scale_sel,
    input wire logic [cclc_pkg::CCLC_CUR_W-1:0] fast_current_prog, fast_current_out,
    // outputs
    input wire logic input_voltage_droop_flag, vterm_reduced, timer_double, test_mode_en, safe_output_regulator,
    input wire logic fast_charge_start
);
    import cclc_pkg::*;
    logic [2:0] up_reg;
    logic up;
    assign up = up_reg == 3'h7;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) up_reg <= 3'h0;
        else if (!up) up_reg <= up_reg + 3'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_sfo_follow: assert property (up |-> safe_output_regulator == $past(vin_above_sfo_on, 3)) else $error("sfo");
    a_start_follow: assert property (up |-> fast_charge_start == $past(done_restart, 3)) else $error("start");
    a_droop_flag: assert property (up |-> input_voltage_droop_flag == $past(vin_below_upper, 3)) else $error("flag");
    a_test_gate: assert property (up && test_mode_en |-> $past(test_mode_bit) && $past(cv_settled, 3))
        else $error("test mode");
    a_cur_cap: assert property (up && $past(fast_current_prog, 4) == fast_current_prog
        |-> fast_current_out <= fast_current_prog) else $error("cap");
    a_cur_floor: assert property (up && !$past(batt_cool, 3) && fast_current_prog != 5'h00
        |-> fast_current_out >= CCLC_CUR_MIN) else $error("floor");
    a_vterm_zone: assert property (up |-> vterm_reduced ==
        ($past(batt_warm, 3) | ($past(safety_region_select) & $past(batt_cool, 3)))) else $error("vterm");
    a_timer_half: assert property (up |-> timer_double ==
        ($past(batt_cool, 3) & !$past(safety_region_select) & ($past(cool_scale_sel) != CCLC_COOL_QUARTER)
        & ($past(cool_scale_sel) != CCLC_COOL_THREEQ)))
        else $error("timer");
    c_cool: cover property (timer_double);
    c_droop: cover property (input_voltage_droop_flag && fast_current_out == CCLC_CUR_MIN);
    c_test: cover property (test_mode_en);
endmodule : cclc_core_chk
bind cclc_core cclc_core_chk u_chk (.*);
`default_nettype wire

// >>> sim/cclc_far_model.sv
`default_nettype none
module cclc_far_model (
    // input voltage, currents and battery temperature
    input wire logic [12:0] vin_mv, in_ma, lim_ma, temp_c,
    // comparator outputs
    output logic vin_below_upper, vin_below_lower, vin_above_sfo_on, input_overcurrent_flag, batt_cool, batt_warm
);
    timeunit 1ns;
    timeprecision 1ns;
    assign vin_below_upper = vin_mv < 13'h1194;
    assign vin_below_lower = vin_mv < 13'h1130;
    assign vin_above_sfo_on = vin_mv > 13'h09C4;
    assign input_overcurrent_flag = in_ma > lim_ma;
    assign batt_cool = temp_c < 13'h000F;
    assign batt_warm = temp_c > 13'h002D;
endmodule : cclc_far_model
`default_nettype wire

// >>> sim/charge_current_limit_control_tb.sv
`default_nettype none
module charge_current_limit_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_n = 1'b0, cv_settled = 1'b0, done_restart = 1'b0;
    logic safety_region_select = 1'b0, test_mode_bit = 1'b0;
    logic [4:0] fast_current_prog = 5'h10, fast_current_out, v;
    logic [4:0] exp_cool [4] = '{5'h08, 5'h04, 5'h0C, 5'h08};
    logic [1:0] cool_scale_sel = 2'h0;
    logic vin_below_upper, vin_below_lower, input_overcurrent_flag, vin_above_sfo_on, batt_cool, batt_warm;
    logic input_voltage_droop_flag, vterm_reduced, timer_double, test_mode_en, safe_output_regulator, fast_charge_start;
    logic [12:0] vin_mv = 13'h1388, in_ma = 13'h0000, lim_ma = 13'h01F4, temp_c = 13'h0019;
    int mismatches = 0, num_checks = 0;
    always #50 ref_clk = ~ref_clk;
    cclc_core #(.RESAMPLE_CYC(20), .SLOW_STEP_CYC(4)) uut (.*);
    cclc_far_model far (.*);
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : w
    task automatic chk(input string s, input logic [4:0] e, input logic [4:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %0d got %0d", s, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        w(6);
        rst_n <= 1'b1;
        w(10);
        chk("cur", 5'h10, fast_current_out);
        vin_mv <= 13'h07D0;
        w(4);
        chk("sfo", 5'h00, {4'h0, safe_output_regulator});
        vin_mv <= 13'h1162;
        w(8);
        chk("flag", 5'h01, {4'h0, input_voltage_droop_flag});
        chk("slow", 5'h01, {4'h0, fast_current_out < 5'h10 && fast_current_out > 5'h09});
        vin_mv <= 13'h10CC;
        w(30);
        chk("floor", 5'h01, fast_current_out);
        vin_mv <= 13'h1388;
        w(50);
        chk("resample", 5'h01, {4'h0, fast_current_out > 5'h01 && fast_current_out < 5'h06});
        w(340);
        chk("recover", 5'h10, fast_current_out);
        in_ma <= 13'h0258;
        w(14);
        in_ma <= 13'h0000;
        w(5);
        chk("oc", 5'h01, {4'h0, fast_current_out < 5'h10});
        v = fast_current_out;
        w(12);
        chk("hold", v, fast_current_out);
        w(400);
        chk("oc_back", 5'h10, fast_current_out);
        $display("limit tests done");
        temp_c <= 13'h0005;
        for (int i = 0; i < 4; i++) begin
            cool_scale_sel <= i[1:0];
            w(5);
            chk("cool", exp_cool[i], fast_current_out);
            chk("timer", {4'h0, i == 0 || i == 3}, {4'h0, timer_double});
        end
        safety_region_select <= 1'b1;
        w(5);
        chk("r2cur", 5'h10, fast_current_out);
        chk("r2vt", 5'h01, {4'h0, vterm_reduced});
        temp_c <= 13'h0032;
        safety_region_select <= 1'b0;
        w(5);
        chk("warm", 5'h01, {4'h0, vterm_reduced});
        $display("temperature tests done");
        cv_settled <= 1'b1;
        test_mode_bit <= 1'b1;
        w(5);
        chk("test", 5'h01, {4'h0, test_mode_en});
        done_restart <= 1'b1;
        w(5);
        chk("start", 5'h01, {4'h0, fast_charge_start});
        $display("mode tests done");
        tally_and_finish;
    end
    initial begin
        w(3000);
        mismatches++;
        tally_and_finish;
    end
endmodule : charge_current_limit_control_tb
`default_nettype wire
